//--- testbench/tb_uis_event_irq.sv
// Self-checking bench for the event status and interrupt block.
`timescale 1ns/100ps
module tb_uis_event_irq;
   import uis_pkg::*;
   logic        clock, resetn, setup, fast, irq;
   logic [7:0]  first;
   logic [7:1]  second;
   logic [31:0] rdata;
   uis_sof_t    sof;
   uis_req_t    req;
   int          err_count, check_count;
   uis_event_irq i_dut (.i_clock(clock), .i_resetn(resetn), .i_req(req),
      .o_reg_rdata(rdata), .i_setup_rcvd(setup), .i_sof(sof),
      .i_fast_speed(fast), .i_first_done(first), .i_second_done(second),
      .o_irq(irq));
   uis_cpu_model i_cpu (.i_clock(clock), .i_rdata(rdata), .o_req(req));
   task automatic complete_run();
      if (err_count == 0 && check_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] v;
      i_cpu.rd(a, v);
      chk(v, exp);
   endtask
   task automatic wait_irq(input logic v);
      int n;
      n = 0;
      while (irq !== v && n < 4) begin
         @(negedge clock);
         n++;
      end
      chk({31'h0000_0000, irq}, {31'h0000_0000, v});
      if (irq !== v) complete_run();
   endtask
   task automatic pulse(input logic [15:0] ep, input logic su, sv);
      @(negedge clock);
      first = ep[7:0];
      second = ep[15:9];
      setup = su;
      sof.valid = sv;
      @(negedge clock);
      first = '0;
      second = '0;
      setup = 1'b0;
      sof.valid = 1'b0;
   endtask
   task automatic t_reset();
      wait_irq(1'b0);
      rchk(12'h108, 32'h0000_0000);
      rchk(12'h10C, 32'h0000_0000);
      rchk(12'h110, 32'h0000_0000);
      rchk(12'h200, 32'h0000_0000);
   endtask
   task automatic t_status();
      fast = 1'b1;
      pulse(16'hFEFF, 1'b1, 1'b1);
      rchk(12'h108, 32'h0007_FEFF);
      rchk(12'h108, 32'h0001_0000);
      fast = 1'b0;
      rchk(12'h108, 32'h0000_0000);
   endtask
   task automatic t_frame();
      i_cpu.wr(12'h110, 32'h8002_0000);
      sof.frame = 11'h7FF;
      sof.uframe = 3'h7;
      pulse(16'h0000, 1'b0, 1'b1);
      wait_irq(1'b1);
      i_cpu.wr(12'h10C, 32'h0000_0000);
      rchk(12'h10C, 32'h0000_3FFF);
      rchk(12'h108, 32'h0002_0000);
      wait_irq(1'b0);
   endtask
   task automatic t_gate();
      i_cpu.wr(12'h110, 32'h0000_0001);
      pulse(16'h0001, 1'b0, 1'b0);
      repeat (3) @(negedge clock);
      wait_irq(1'b0);
      i_cpu.wr(12'h110, 32'h8000_0001);
      wait_irq(1'b1);
      i_cpu.wr(12'h110, 32'h8000_0000);
      wait_irq(1'b0);
      i_cpu.wr(12'h110, 32'h8000_0003);
      wait_irq(1'b1);
      pulse(16'h0002, 1'b0, 1'b0);
      i_cpu.wr(12'h108, 32'h0000_0001);
      wait_irq(1'b0);
      wait_irq(1'b1);
      i_cpu.wr(12'h108, 32'h0000_0002);
      wait_irq(1'b0);
      rchk(12'h108, 32'h0000_0000);
      i_cpu.wr(12'h110, 32'hFFFF_FFFF);
      rchk(12'h110, 32'h8007_FEFF);
   endtask
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      resetn = 1'b0;
      setup = 1'b0;
      fast = 1'b0;
      first = '0;
      second = '0;
      sof = '0;
      err_count = 0;
      check_count = 0;
      repeat (2) @(posedge clock);
      @(negedge clock);
      resetn = 1'b1;
      t_reset();
      t_status();
      t_frame();
      t_gate();
      complete_run();
   end
endmodule // tb_uis_event_irq

//--- testbench/uis_cpu_model.sv
// Processor side model that issues register reads and writes.
`timescale 1ns/100ps
module uis_cpu_model (
   input  wire logic          i_clock,
   input  wire logic [31:0]   i_rdata,
   output uis_pkg::uis_req_t  o_req
);
   import uis_pkg::*;
   initial o_req = '0;
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      @(negedge i_clock);
      o_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(negedge i_clock);
      o_req = '0;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] v);
      @(negedge i_clock);
      o_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(negedge i_clock);
      o_req = '0;
      v = i_rdata;
   endtask
endmodule // uis_cpu_model

//--- verilog/uis_event_irq.sv
// Event status, interrupt line and frame number registers of the device.
//
// How it works
// - Bit 18 latches when a control endpoint setup packet arrives.
// - Bit 17 latches whenever a start-of-frame packet arrives.
// - Bit 16 reads 1 at high speed, 0 at full speed.
// - Bits 15..9 latch second buffer done of endpoints 7..1; bit 8 reserved.
// - Bits 7..0 latch first buffer done of endpoints 7..0.
// - One interrupt output, signalled by a low to high edge.
// - Per-bit enables gate each source; master enable blocks all.
// - Writing 1 to any status bit except bit 16 clears it and its interrupt condition.
// - After reset the interrupt output is low.
// - Interrupt asserts when the master enable is 1 and any status bit and its enable are both 1.
// - Enabling a source whose status is already 1 asserts the interrupt.
// - A status read that clears an enabled bit drops the interrupt.
// - Disabling a source whose status is 1 drops the interrupt.
// - Drop and raise together: drop one cycle, then raise if still due.
// - Frame number reads at bits 13..3; bits 31..14 read zero.
// - Microframe number reads in bits 2..0, loaded from each token.
// - Enable register at 0x0110, master at bit 31, sources as status.
`timescale 1ns/100ps
`include "uis_map.svh"

module uis_event_irq #(
   parameter bit CLR_ON_READ = 1'b1
) (
   input  wire logic             i_clock,
   input  wire logic             i_resetn,
   input  wire uis_pkg::uis_req_t i_req,
   output logic [31:0]           o_reg_rdata,
   input  wire logic             i_setup_rcvd,
   input  wire uis_pkg::uis_sof_t i_sof,
   input  wire logic             i_fast_speed,
   input  wire logic [7:0]       i_first_done,
   input  wire logic [7:1]       i_second_done,
   output logic                  o_irq
);
   import uis_pkg::*;

   logic [31:0]    status_r;
   logic [31:0]    status_nxt;
   logic [31:0]    enable_r;
   logic [31:0]    enable_nxt;
   logic [31:0]    rdata_r;
   logic [31:0]    rdata_nxt;
   logic [10:0]    frame_r;
   logic [10:0]    frame_nxt;
   logic [2:0]     uframe_r;
   logic [2:0]     uframe_nxt;
   uis_irq_state_t irq_state_r;
   uis_irq_state_t irq_state_nxt;
   logic [31:0]    evt_set;
   logic [31:0]    clr;
   logic [31:0]    view;
   logic [31:0]    view_nxt;
   logic           hit_status;
   logic           hit_enable;
   logic           drop;
   logic           due_nxt;

   // Register decode, event capture and clearing.
   always_comb begin
      hit_status = i_req.addr == `UIS_OFS_STATUS;
      hit_enable = i_req.addr == `UIS_OFS_ENABLE;
      evt_set = `UIS_ZERO_WORD;
      evt_set[`UIS_BIT_SETUP] = i_setup_rcvd;
      evt_set[`UIS_BIT_SOF] = i_sof.valid;
      evt_set[`UIS_BIT_SECOND_LO +: 7] = i_second_done;
      evt_set[`UIS_BIT_FIRST_LO +: 8] = i_first_done;
      view = status_r;
      view[`UIS_BIT_FAST] = i_fast_speed;
      clr = `UIS_ZERO_WORD;
      if (i_req.wr && hit_status) begin
         clr = i_req.wdata & `UIS_STICKY_MASK;
      end
      if (i_req.rd && hit_status && CLR_ON_READ) begin
         clr = clr | (status_r & `UIS_STICKY_MASK);
      end
   end

   // Sticky bits; a new event in the clearing cycle keeps its bit set.
   always_comb begin
      status_nxt = ((status_r & ~clr) | evt_set) & `UIS_STICKY_MASK;
      view_nxt = status_nxt;
      view_nxt[`UIS_BIT_FAST] = i_fast_speed;
   end

   // Enable register with its master gate.
   always_comb begin
      enable_nxt = enable_r;
      if (i_req.wr && hit_enable) begin
         enable_nxt = i_req.wdata & `UIS_ENABLE_MASK;
      end
   end

   // Read data path; unmapped offsets read as zero.
   always_comb begin
      rdata_nxt = rdata_r;
      if (i_req.rd) begin
         case (i_req.addr)
            `UIS_OFS_STATUS: begin
               rdata_nxt = view;
            end
            `UIS_OFS_ENABLE: begin
               rdata_nxt = enable_r;
            end
            `UIS_OFS_FRAME: begin
               rdata_nxt = `UIS_ZERO_WORD;
               rdata_nxt[`UIS_FRAME_LO +: 11] = frame_r;
               rdata_nxt[`UIS_UFRAME_LO +: 3] = uframe_r;
            end
            default: begin
               rdata_nxt = `UIS_ZERO_WORD;
            end
         endcase
      end
   end

   // Frame and microframe capture from each token.
   always_comb begin
      frame_nxt = frame_r;
      uframe_nxt = uframe_r;
      if (i_sof.valid) begin
         frame_nxt = i_sof.frame;
         uframe_nxt = i_sof.uframe;
      end
   end

   // Interrupt line sequencing.
   always_comb begin
      drop = 1'b0;
      if (enable_r[`UIS_BIT_MASTER]) begin
         if (|(clr & view & enable_r & `UIS_SOURCE_MASK)) begin
            drop = 1'b1;
         end
         if (|(enable_r & ~enable_nxt & view & `UIS_SOURCE_MASK)) begin
            drop = 1'b1;
         end
      end
      if (enable_r[`UIS_BIT_MASTER] && !enable_nxt[`UIS_BIT_MASTER]) begin
         drop = 1'b1;
      end
      due_nxt = enable_nxt[`UIS_BIT_MASTER] &&
                (|(view_nxt & enable_nxt & `UIS_SOURCE_MASK));
      case (irq_state_r)
         UIS_IRQ_IDLE: begin
            irq_state_nxt = due_nxt ? UIS_IRQ_HIGH : UIS_IRQ_IDLE;
         end
         UIS_IRQ_HIGH: begin
            if (drop) begin
               irq_state_nxt = UIS_IRQ_DROP;
            end else if (due_nxt) begin
               irq_state_nxt = UIS_IRQ_HIGH;
            end else begin
               irq_state_nxt = UIS_IRQ_IDLE;
            end
         end
         UIS_IRQ_DROP: begin
            irq_state_nxt = due_nxt ? UIS_IRQ_HIGH : UIS_IRQ_IDLE;
         end
         default: begin
            irq_state_nxt = UIS_IRQ_IDLE;
         end
      endcase
   end

   // Status register.
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         status_r <= `UIS_ZERO_WORD;
      end else begin
         status_r <= status_nxt;
      end
   end

   // Enable register.
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         enable_r <= `UIS_ZERO_WORD;
      end else begin
         enable_r <= enable_nxt;
      end
   end

   // Read data register.
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_r <= `UIS_ZERO_WORD;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // Frame and microframe registers.
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         frame_r  <= `UIS_FRAME_RST;
         uframe_r <= `UIS_UFRAME_RST;
      end else begin
         frame_r  <= frame_nxt;
         uframe_r <= uframe_nxt;
      end
   end

   // Interrupt line state.
   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_state_r <= UIS_IRQ_IDLE;
      end else begin
         irq_state_r <= irq_state_nxt;
      end
   end

   assign o_reg_rdata = rdata_r;
   assign o_irq = irq_state_r == UIS_IRQ_HIGH;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_resetn);

   AST_SETUP_STICKY: assert property (
      i_setup_rcvd |=> status_r[`UIS_BIT_SETUP])
      else $error("Setup event did not set its status bit.");
   AST_SOF_STICKY: assert property (
      i_sof.valid |=> status_r[`UIS_BIT_SOF])
      else $error("Frame token did not set its status bit.");
   AST_SPEED_VIEW: assert property (
      i_req.rd && hit_status |=> o_reg_rdata[`UIS_BIT_FAST] ==
                                 $past(i_fast_speed))
      else $error("Speed bit does not follow the speed input.");
   AST_RESERVED_ZERO: assert property (
      status_r[8] == 1'b0 && status_r[31:19] == 13'h0000)
      else $error("Reserved status bit is set.");
   AST_EP_DONE: assert property (
      i_first_done != 8'h00 |=> (status_r[7:0] & $past(i_first_done)) ==
                                $past(i_first_done))
      else $error("Buffer done event lost.");
   AST_W1C: assert property (
      i_req.wr && hit_status && i_req.wdata[`UIS_BIT_SETUP] &&
      !i_setup_rcvd |=> !status_r[`UIS_BIT_SETUP])
      else $error("Write of one did not clear the status bit.");
   AST_IRQ_LEVEL: assert property (
      due_nxt && !drop |=> o_irq)
      else $error("Interrupt not raised for an enabled set bit.");
   AST_MASTER_BLOCK: assert property (
      !enable_r[`UIS_BIT_MASTER] |-> !o_irq)
      else $error("Interrupt high with master gate off.");
   AST_DROP_FIRST: assert property (
      o_irq && drop |=> !o_irq ##1 (o_irq == $past(due_nxt)))
      else $error("Interrupt not dropped for one cycle.");
   AST_FRAME_LOAD: assert property (
      i_sof.valid |=> frame_r == $past(i_sof.frame) &&
                      uframe_r == $past(i_sof.uframe))
      else $error("Frame fields not loaded from the token.");
   AST_IRQ_CAUSE: assert property (
      o_irq |-> $past(due_nxt))
      else $error("Interrupt high without an enabled set bit.");

   AST_SETUP_QUIET: assert property (
      !status_r[`UIS_BIT_SETUP] && !i_setup_rcvd |=>
      !status_r[`UIS_BIT_SETUP])
      else $error("Setup status bit set without a setup event.");

   AST_SPEED_NOT_STICKY: assert property (
      !status_r[`UIS_BIT_FAST])
      else $error("Speed bit was latched in the status register.");

   AST_SECOND_DONE: assert property (
      i_second_done != 7'h00 |=>
      (status_r[`UIS_BIT_SECOND_LO +: 7] & $past(i_second_done)) ==
      $past(i_second_done))
      else $error("Second buffer done event lost.");

   AST_IRQ_RISE: assert property (
      $rose(o_irq) |-> $past(due_nxt))
      else $error("Interrupt rose without a due source.");

   AST_W1C_FIRST: assert property (
      i_req.wr && hit_status && i_req.wdata[`UIS_BIT_FIRST_LO] &&
      !i_first_done[0] |=> !status_r[`UIS_BIT_FIRST_LO])
      else $error("Write of one did not clear the buffer done bit.");

   AST_IRQ_RESET_LOW: assert property (
      $rose(i_resetn) |-> !o_irq)
      else $error("Interrupt high right after reset.");

   AST_IRQ_LOW_IDLE: assert property (
      !due_nxt |=> !o_irq)
      else $error("Interrupt high with no enabled set bit.");

   AST_ENABLE_LATE: assert property (
      enable_nxt[`UIS_BIT_MASTER] && !drop &&
      |(enable_nxt & ~enable_r & view_nxt & `UIS_SOURCE_MASK) |=> o_irq)
      else $error("Late enable of a set bit did not raise interrupt.");

   AST_READ_DROP: assert property (
      o_irq && i_req.rd && hit_status && CLR_ON_READ &&
      |(view & enable_r & `UIS_STICKY_MASK) |=> !o_irq)
      else $error("Clearing status read did not drop the interrupt.");

   AST_DISABLE_DROP: assert property (
      o_irq && |(enable_r & ~enable_nxt & view & `UIS_SOURCE_MASK) |=>
      !o_irq)
      else $error("Disabling a set source did not drop the interrupt.");

   AST_FRAME_READ: assert property (
      i_req.rd && i_req.addr == `UIS_OFS_FRAME |=>
      o_reg_rdata == {18'h0_0000, $past(frame_r), $past(uframe_r)})
      else $error("Frame register read shows wrong fields.");

   AST_UFRAME_LOAD: assert property (
      i_sof.valid |=> uframe_r == $past(i_sof.uframe))
      else $error("Microframe not loaded from the token.");

   AST_ENABLE_WRITE: assert property (
      i_req.wr && hit_enable |=>
      enable_r == ($past(i_req.wdata) & `UIS_ENABLE_MASK))
      else $error("Enable register write not taken.");

   AST_STICKY_HOLD: assert property (
      status_r[`UIS_BIT_SETUP] && !clr[`UIS_BIT_SETUP] |=>
      status_r[`UIS_BIT_SETUP])
      else $error("Status bit lost without a clear.");

   AST_FRAME_HOLD: assert property (
      !i_sof.valid |=> $stable(frame_r) && $stable(uframe_r))
      else $error("Frame fields changed without a token.");

   COV_IRQ_RISE: cover property (!o_irq ##1 o_irq);
   COV_DROP_REASSERT: cover property (o_irq ##1 !o_irq ##1 o_irq);
   COV_SET_AND_CLEAR: cover property (
      i_setup_rcvd && i_req.wr && hit_status &&
      i_req.wdata[`UIS_BIT_SETUP]);
   COV_FRAME_READ: cover property (
      i_req.rd && i_req.addr == `UIS_OFS_FRAME);
   COV_ENABLE_LATE: cover property (
      enable_r[`UIS_BIT_MASTER] && !enable_r[`UIS_BIT_FIRST_LO] &&
      enable_nxt[`UIS_BIT_FIRST_LO] && status_r[`UIS_BIT_FIRST_LO]);

endmodule // uis_event_irq

//--- verilog/uis_map.svh
// Register offsets, field positions and reset values of the event block.
`ifndef UIS_MAP_SVH
`define UIS_MAP_SVH
`define UIS_ADDR_W          12
`define UIS_OFS_STATUS      12'h0108
`define UIS_OFS_FRAME       12'h010C
`define UIS_OFS_ENABLE      12'h0110
`define UIS_BIT_MASTER      31
`define UIS_BIT_SETUP       18
`define UIS_BIT_SOF         17
`define UIS_BIT_FAST        16
`define UIS_BIT_SECOND_LO   9
`define UIS_BIT_FIRST_LO    0
`define UIS_STICKY_MASK     32'h0006_FEFF
`define UIS_SOURCE_MASK     32'h0007_FEFF
`define UIS_ENABLE_MASK     32'h8007_FEFF
`define UIS_ZERO_WORD       32'h0000_0000
`define UIS_FRAME_LO        3
`define UIS_UFRAME_LO       0
`define UIS_FRAME_RST       11'h000
`define UIS_UFRAME_RST      3'h0
`endif

//--- verilog/uis_pkg.sv
// Types shared by the event status and frame number block.
package uis_pkg;
   typedef struct packed {
      logic        valid;
      logic [10:0] frame;
      logic [2:0]  uframe;
   } uis_sof_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [31:0] wdata;
   } uis_req_t;

   typedef enum logic [1:0] {
      UIS_IRQ_IDLE,
      UIS_IRQ_HIGH,
      UIS_IRQ_DROP
   } uis_irq_state_t;
endpackage
